// File: inc/warmup_pkg.sv
// Package for the oscillator warm-up counter: control layouts, codes and counts
package warmup_pkg;
  // Lower timer control byte layout
  localparam int LOW_FLOP_BIT = 7;
  localparam int LOW_SRC_LSB = 4;
  localparam int LOW_SRC_MSB = 6;
  localparam int LOW_MODE_LSB = 0;
  localparam int LOW_MODE_MSB = 2;
  // Upper timer control byte layout
  localparam int UP_FLOP_BIT = 7;
  localparam int UP_RUN_BIT = 3;
  localparam int UP_MODE_LSB = 0;
  localparam int UP_MODE_MSB = 2;
  localparam logic [2:0] SRC_SLOW = 3'h4;
  localparam logic [2:0] SRC_FAST = 3'h6;
  localparam logic [2:0] LOW_MODE_CASCADE = 3'h3;
  localparam logic [2:0] UP_MODE_WARMUP = 3'h5;
  localparam logic [7:0] LOWER_CTRL_RESET = 8'h00;
  localparam logic [7:0] UPPER_CTRL_RESET = 8'h00;
  localparam logic [7:0] PERIOD_HIGH_RESET = 8'hFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] PERIOD_LOW_RESET = 8'h00;
  // Counter is built from cascaded byte stages
  localparam int BYTE_W = 8;
  localparam int COUNT_BYTES = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_COUNT = 3'b010,
    ST_MISCONF = 3'b100
  } warm_state_e;

  typedef struct packed {
    logic [7:0] lowerTimerControl;
    logic [7:0] upperTimerControl;
    logic [7:0] periodLowByte;
    logic [7:0] periodHighByte;
  } warm_cfg_s;

  typedef struct packed {
    logic running;
    logic slowSource;
    logic modeValid;
    logic [15:0] count;
  } warm_status_s;
endpackage

// File: src/source_tick.sv
// Two-stage synchroniser and edge detector for the selected timer source clock
`timescale 1ns/1ps
`default_nettype none
module source_tick (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic fastSrc, // Fast oscillator source level
  input wire logic slowSrc, // Slow oscillator source level
  input wire logic selSlow, // High selects slow source
  output logic tick // One-cycle pulse per source rising edge
);
  logic [1:0] fastSync_q;
  logic [1:0] slowSync_q;
  logic prev_q;
  logic cur;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fastSync_q <= 2'h0;
      slowSync_q <= 2'h0;
    end else begin
      fastSync_q <= {fastSync_q[0], fastSrc};
      slowSync_q <= {slowSync_q[0], slowSrc};
    end
  end

  // Only the second stages feed the selector
  assign cur = selSlow ? slowSync_q[1] : fastSync_q[1];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= cur;
    end
  end

  assign tick = cur & ~prev_q;
endmodule
`default_nettype wire

// File: src/oscillator_warmup_counter.sv
// Warm-up counter mode of two cascaded 8-bit timers forming one 16-bit up-counter
// Summary of operation
// - In warm-up mode the two timers form one 16-bit up-counter clocked by the source chosen in lower control.
// - Matching uses only the upper byte of the period pair; the lower period byte is ignored.
// - On a match the counter clears to zero and the match interrupt request is raised.
// - Counting starts when software sets the run bit in upper control and stops when it clears it.
// - Lower control 43H selects slow source with cascade and flop 0; 63H selects fast source likewise.
// - Upper control 05H selects warm-up mode with upper flop 0 and the counter stopped.
// - At 32.768 kHz, period settings 0100H to FF00H give about 7.81 ms to 1.99 s.
// - On the fast source the same settings give about 16 us to 4.08 ms.
`timescale 1ns/1ps
`default_nettype none
module oscillator_warmup_counter
  import warmup_pkg::*;
(
  input wire logic clk, // System clock, 40 MHz
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic fastSource, // Fast oscillator source clock (pin)
  input wire logic slowSource, // Slow oscillator source clock (pin)
  input wire logic lowerCtrlWe, // Write strobe for lower timer control
  input wire logic upperCtrlWe, // Write strobe for upper timer control
  input wire logic periodLowWe, // Write strobe for period low byte
  input wire logic periodHighWe, // Write strobe for period high byte
  input wire logic [7:0] writeData, // Write data for all strobes
  output warmup_pkg::warm_cfg_s cfg, // Current control and period bytes
  output warmup_pkg::warm_status_s status, // Counter state
  output logic warmupMatchIrq // One-cycle match interrupt request
);
  import warmup_pkg::*;

  logic [7:0] lowerCtrl_q;
  logic [7:0] upperCtrl_q;
  logic [7:0] periodLow_q;
  logic [7:0] periodHigh_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic irq_q;
  logic irq_d;
  warm_state_e state_q;
  warm_state_e state_d;
  logic tick;
  logic selSlow;
  logic modeOk;
  logic runBit;
  logic matchHit;
  logic selSlowPrev_q;
  logic tickOk;
  logic lowModeOk;
  logic upModeOk;
  logic srcOk;
  logic startReq;
  logic countEn;
  logic [COUNT_BYTES-1:0] byteCarry;
  logic [15:0] countStep;

  source_tick srcTick (
    .clk(clk),
    .sys_rst(sys_rst),
    .fastSrc(fastSource),
    .slowSrc(slowSource),
    .selSlow(selSlow),
    .tick(tick)
  );

  // Control and period bytes, one register each
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lowerCtrl_q <= LOWER_CTRL_RESET;
    end else begin
      if (lowerCtrlWe) begin
        lowerCtrl_q <= writeData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upperCtrl_q <= UPPER_CTRL_RESET;
    end else begin
      if (upperCtrlWe) begin
        upperCtrl_q <= writeData;
      end
    end
  end

  // The low period byte is kept for software only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periodLow_q <= PERIOD_LOW_RESET;
    end else begin
      if (periodLowWe) begin
        periodLow_q <= writeData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periodHigh_q <= PERIOD_HIGH_RESET;
    end else begin
      if (periodHighWe) begin
        periodHigh_q <= writeData;
      end
    end
  end

  // Source choice follows the lower control byte; the fast code is the default
  assign selSlow = (lowerCtrl_q[LOW_SRC_MSB:LOW_SRC_LSB] == SRC_SLOW);
  assign lowModeOk = (lowerCtrl_q[LOW_MODE_MSB:LOW_MODE_LSB] == LOW_MODE_CASCADE);
  assign upModeOk = (upperCtrl_q[UP_MODE_MSB:UP_MODE_LSB] == UP_MODE_WARMUP);
  // Any other source code sends a run request to misconfig rather than counting an unknown clock
  assign srcOk = (lowerCtrl_q[LOW_SRC_MSB:LOW_SRC_LSB] == SRC_SLOW)
    || (lowerCtrl_q[LOW_SRC_MSB:LOW_SRC_LSB] == SRC_FAST);
  assign modeOk = lowModeOk && upModeOk && srcOk;
  assign runBit = upperCtrl_q[UP_RUN_BIT];

  // A source change pairs the old edge history with the new pin; drop that one tick
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selSlowPrev_q <= 1'b0;
    end else begin
      selSlowPrev_q <= selSlow;
    end
  end
  assign tickOk = tick && (selSlow == selSlowPrev_q);

  // Low period byte deliberately unused in the compare
  assign matchHit = (count_q[(COUNT_BYTES - 1) * BYTE_W +: BYTE_W] == periodHigh_q);

  // Two cascaded byte stages; a higher byte steps only when every lower bit is one
  assign byteCarry[0] = 1'b1;
  for (genvar b = 0; b < COUNT_BYTES; b++) begin : g_byte
    assign countStep[b * BYTE_W +: BYTE_W] = count_q[b * BYTE_W +: BYTE_W]
      + {{(BYTE_W - 1){1'b0}}, byteCarry[b]};
    if (b + 1 < COUNT_BYTES) begin : g_carry
      assign byteCarry[b + 1] = byteCarry[b] & (&count_q[b * BYTE_W +: BYTE_W]);
    end
  end

  // A run request with a bad decode parks in misconfig until software fixes or stops it
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (runBit && modeOk) begin
          state_d = ST_COUNT;
        end else if (runBit) begin
          state_d = ST_MISCONF;
        end
      end
      ST_COUNT: begin
        if (!runBit) begin
          state_d = ST_IDLE;
        end else if (!modeOk) begin
          state_d = ST_MISCONF;
        end
      end
      ST_MISCONF: begin
        if (!runBit) begin
          state_d = ST_IDLE;
        end else if (modeOk) begin
          state_d = ST_COUNT;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Counter holds its value while stopped so software can inspect it
  assign startReq = (state_q == ST_IDLE) && runBit && modeOk;
  assign countEn = (state_q == ST_COUNT) && runBit && tickOk;
  always_comb begin
    count_d = count_q;
    irq_d = 1'b0;
    if (countEn) begin
      if (matchHit) begin
        count_d = COUNT_RESET;
        irq_d = 1'b1;
      end else begin
        count_d = countStep;
      end
    end else if (startReq) begin
      // A start from idle always measures from zero, whatever a stop left behind; leaving misconfig keeps the count
      count_d = COUNT_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= COUNT_RESET;
      irq_q <= 1'b0;
    end else begin
      count_q <= count_d;
      irq_q <= irq_d;
    end
  end

  assign warmupMatchIrq = irq_q;
  always_comb begin
    cfg.lowerTimerControl = lowerCtrl_q;
    cfg.upperTimerControl = upperCtrl_q;
    cfg.periodLowByte = periodLow_q;
    cfg.periodHighByte = periodHigh_q;
    status.running = (state_q == ST_COUNT);
    status.slowSource = selSlow;
    status.modeValid = modeOk;
    status.count = count_q;
  end
endmodule
`default_nettype wire

// File: sim/oscillator_warmup_counter_asserts.sv
// Port checker for the warm-up counter
`timescale 1ns/1ps
`default_nettype none
module oscillator_warmup_counter_asserts
  import warmup_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic fastSource, // Fast source
  input wire logic slowSource, // Slow source
  input wire logic lowerCtrlWe, // Lower write
  input wire logic upperCtrlWe, // Upper write
  input wire logic periodLowWe, // Low byte write
  input wire logic periodHighWe, // High byte write
  input wire logic [7:0] writeData, // Data
  input wire warmup_pkg::warm_cfg_s cfg, // Config
  input wire warmup_pkg::warm_status_s status, // Status
  input wire logic warmupMatchIrq // Match pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire logic [2:0] src = cfg.lowerTimerControl[6:4];
  AST_IRQ_CLEAR: assert property (warmupMatchIrq |-> status.count == 16'h0000) else $error("no clear on match");
  AST_IRQ_PULSE: assert property (warmupMatchIrq |=> !warmupMatchIrq) else $error("irq too long");
  AST_MATCH: assert property (warmupMatchIrq |-> $past(status.count[15:8]) == $past(cfg.periodHighByte))
    else $error("match on wrong byte");
  AST_STEP: assert property ($past(status.running) && $changed(status.count) && status.count != 16'h0000
    |-> status.count == $past(status.count) + 16'h0001) else $error("bad step");
  AST_HOLD: assert property (!status.running ##1 !status.running |-> $stable(status.count)) else $error("moved stopped");
  AST_START: assert property ($rose(cfg.upperTimerControl[UP_RUN_BIT]) && status.modeValid
    |-> ##[0:1] (status.running && status.count == 16'h0000)) else $error("no start");
  AST_STOP: assert property ($fell(cfg.upperTimerControl[UP_RUN_BIT]) |-> ##[0:1] !status.running) else $error("no stop");
  AST_DECODE: assert property (status.modeValid == (cfg.lowerTimerControl[2:0] == 3'h3
    && cfg.upperTimerControl[2:0] == 3'h5 && (src == 3'h4 || src == 3'h6))) else $error("bad decode");
  AST_WRITE: assert property (upperCtrlWe |=> cfg.upperTimerControl == $past(writeData)) else $error("bad write");
endmodule
bind oscillator_warmup_counter oscillator_warmup_counter_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
  .fastSource(fastSource), .slowSource(slowSource), .lowerCtrlWe(lowerCtrlWe), .upperCtrlWe(upperCtrlWe),
  .periodLowWe(periodLowWe), .periodHighWe(periodHighWe), .writeData(writeData), .cfg(cfg), .status(status),
  .warmupMatchIrq(warmupMatchIrq));
`default_nettype wire

// File: sim/oscillator_warmup_counter_test.sv
// Self-checking bench for the warm-up counter
`timescale 1ns/1ps
`default_nettype none
module oscillator_warmup_counter_test;
  import warmup_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fastSource = 1'b0;
  logic slowSource = 1'b0;
  logic [3:0] we = 4'h0;
  logic [7:0] writeData = 8'h00;
  logic [7:0] cyc = 8'h00;
  warm_cfg_s cfg;
  warm_status_s status;
  logic warmupMatchIrq;
  logic [31:0] seed = 32'h63;
  int n_fail = 0;
  int compares = 0;
  oscillator_warmup_counter u_oscillator_warmup_counter (.clk(clk), .sys_rst(sys_rst),
    .fastSource(fastSource), .slowSource(slowSource), .lowerCtrlWe(we[3]), .upperCtrlWe(we[2]),
    .periodLowWe(we[1]), .periodHighWe(we[0]), .writeData(writeData), .cfg(cfg), .status(status),
    .warmupMatchIrq(warmupMatchIrq));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Fast source runs at a quarter of clk, slow at a sixteenth
  always @(posedge clk) begin
    cyc <= cyc + 8'h01;
    fastSource <= cyc[1];
    slowSource <= cyc[3];
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic valid(input logic [7:0] lo);
    return lo[2:0] == 3'h3 && (lo[6:4] == 3'h4 || lo[6:4] == 3'h6);
  endfunction
  // Clocks between interrupts: only the high byte counts, plus the clearing tick
  function automatic int irqPeriod(input logic [7:0] hi, input int per);
    return (int'(hi) * 256 + 1) * per;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int s, input logic [7:0] d);
    @(posedge clk);
    we <= 4'h8 >> s;
    writeData <= d;
    @(posedge clk);
    we <= 4'h0;
  endtask
  task automatic waitIrq(output int n);
    n = 0;
    while (warmupMatchIrq !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(32'(warmupMatchIrq), 32'h1);
  endtask
  task automatic conclude();
    $display("fails=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run(input logic [7:0] lo, input logic [7:0] hi, input int per);
    int n;
    logic [15:0] c;
    logic [7:0] r;
    r = 8'(xs());
    wr(0, lo);
    wr(1, 8'h05);
    wr(2, r);
    wr(3, hi);
    wr(1, 8'h0D);
    @(negedge clk);
    chk(cfg, {lo, 8'h0D, r, hi});
    waitIrq(n);
    chk(32'(status.count), 32'h0);
    @(negedge clk);
    waitIrq(n);
    chk(n + 1, irqPeriod(hi, per));
    chk(32'(status.slowSource), 32'(lo == 8'h43));
    wr(1, 8'h05);
    repeat (3) @(negedge clk);
    c = status.count;
    repeat (40) @(negedge clk);
    chk(32'(status.count), 32'(c));
    chk(32'(status.running), 32'h0);
  endtask
  initial begin
    logic [7:0] d;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk(cfg, 32'h000000FF);
    chk(32'(status.count), 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = i == 0 ? 8'h43 : i == 1 ? 8'h63 : i == 2 ? 8'h53 : 8'(xs());
      wr(0, d);
      wr(1, 8'h05);
      @(negedge clk);
      chk(32'(status.modeValid), 32'(valid(d)));
    end
    wr(0, 8'h53);
    wr(1, 8'h0D);
    repeat (8) @(negedge clk);
    chk(32'(status.running), 32'h0);
    chk(32'(status.modeValid), 32'h0);
    run(8'h43, 8'h01, 16);
    run(8'h63, 8'h02, 4);
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
